// ---- tmss_defines.vh ----
// constants for the touch matrix scan sequencer
`ifndef TMSS_DEFINES_VH
`define TMSS_DEFINES_VH
`define TMSS_LINES 8
`define TMSS_KEYS 64
`define TMSS_BL_W 8
`define TMSS_DI_W 8
`define TMSS_CNT_W 12
`define TMSS_RES_W 12
`define TMSS_DWELL_MIN_NS 125
`define TMSS_CLK_PERIOD_NS 10
// least time: round up
`define TMSS_DWELL_MIN_CYC ((`TMSS_DWELL_MIN_NS + `TMSS_CLK_PERIOD_NS - 1) / `TMSS_CLK_PERIOD_NS)
`define TMSS_PULSE_HALF_CYC 8
`define TMSS_CONV_MAX 4095
`endif

// ---- tmss_scan.v ----
// touch matrix scan sequencer: drive bursts, charge gating, slope conversion
// What this block does
// RQ1: key number is receive line times eight plus drive line, 0 to 63.
// RQ2: each matrix scan starts at drive line 0, receive line 0.
// RQ3: drive lines 0 to 7 in order, receive lines 0 to 7 within each.
// RQ4: keys on one drive line share one burst sized by per-key lengths.
// RQ5: whole burst on a drive line ends before the next line starts.
// RQ6: after each burst convert each receive line whose key is enabled, one result per enabled key.
// RQ7: each receive line captures only for its own key's pulse count.
// RQ8: disabled keys are skipped in measurement and results.
// RQ9: drive lines with all keys disabled get no burst timeslot.
// RQ10: integrator setting zero means disabled, nonzero means enabled.
// RQ11: host must disable key positions without electrodes.
// RQ12: removal shortens full scan time only, not per-key timing.
// RQ13: single-slope conversion per receive line.
// RQ14: up to 64 keys supported.
// RQ15: host must read back and check self-test results.
// RQ16: charge capture dwell after each rising edge is adjustable, at least 125 ns.
// RQ17: after last enabled line, restart at first enabled line, repeat.
`timescale 1ns/10ps
`include "tmss_defines.vh"
module tmss_scan #(
    parameter LINES = `TMSS_LINES,
    parameter BL_W = `TMSS_BL_W,
    parameter DI_W = `TMSS_DI_W,
    parameter CNT_W = `TMSS_CNT_W,
    parameter RES_W = `TMSS_RES_W,
    parameter HALF_CYC = `TMSS_PULSE_HALF_CYC
) (
    input wire core_clk_in,
    input wire rst_in,
    input wire scan_enable_in,
    // flat per-key settings, key k at bits [k*W +: W]
    input wire [64*BL_W-1:0] burst_pulse_count_in,
    input wire [64*DI_W-1:0] key_detect_integrator_in,
    input wire [CNT_W-1:0] dwell_cycles_in,
    // comparator per receive line: high while ramp below threshold
    input wire [7:0] slope_compare_in,
    output reg [7:0] drive_line_out,
    output reg [7:0] charge_capture_out,
    output reg [7:0] ramp_enable_out,
    output reg [7:0] discharge_out,
    output reg [2:0] drive_index_out,
    output reg result_valid_out,
    output reg [5:0] result_key_out,
    output reg [RES_W-1:0] result_value_out,
    output reg scan_done_out
);
    localparam S_IDLE = 6'h01;
    localparam S_SEEK = 6'h02;
    localparam S_HIGH = 6'h04;
    localparam S_LOW = 6'h08;
    localparam S_CONV = 6'h10;
    localparam S_EMIT = 6'h20;
    localparam [CNT_W-1:0] DWELL_MIN = `TMSS_DWELL_MIN_CYC;
    localparam [CNT_W-1:0] HALF = HALF_CYC;
    localparam [RES_W-1:0] CONV_MAX = `TMSS_CONV_MAX;

    reg [5:0] state;
    reg [2:0] xi;
    reg [2:0] yi;
    reg [BL_W-1:0] pulse;
    reg [CNT_W-1:0] tmr;
    reg [RES_W-1:0] conv_cnt;
    reg [7:0] conv_run;
    reg [RES_W*8-1:0] conv_val;
    reg started;

    wire [63:0] key_en;
    wire [7:0] line_en;
    wire [BL_W*8-1:0] line_bl;
    wire [CNT_W-1:0] dwell;
    reg [BL_W-1:0] burst_max;
    integer i;
    // own loop index so the max search has no shared driver
    integer m;

    genvar g;
    generate
        for (g = 0; g < 64; g = g + 1)
        begin : g_key
            // key number = receive * 8 + drive
            assign key_en[g] = |key_detect_integrator_in[g*DI_W +: DI_W]; // see RQ10 RQ1
        end
        for (g = 0; g < 8; g = g + 1)
        begin : g_line
            // receive line g on current drive line
            assign line_bl[g*BL_W +: BL_W] = key_en[g*8 + xi] ?
                burst_pulse_count_in[(g*8)*BL_W + xi*BL_W +: BL_W] :
                {BL_W{1'b0}}; // see RQ8 RQ1
            assign line_en[g] = |{key_en[g], key_en[8+g], key_en[16+g],
                key_en[24+g], key_en[32+g], key_en[40+g], key_en[48+g],
                key_en[56+g]}; // see RQ9
        end
    endgenerate

    // clamp short dwell to the 125 ns floor
    assign dwell = (dwell_cycles_in < DWELL_MIN) ? DWELL_MIN :
        dwell_cycles_in; // see RQ16

    always @*
    begin
        burst_max = {BL_W{1'b0}};
        for (m = 0; m < 8; m = m + 1)
            if (line_bl[m*BL_W +: BL_W] > burst_max)
                burst_max = line_bl[m*BL_W +: BL_W]; // see RQ4
    end

    always @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state <= S_IDLE;
            xi <= 3'h0;
            yi <= 3'h0;
            pulse <= {BL_W{1'b0}};
            tmr <= {CNT_W{1'b0}};
            conv_cnt <= {RES_W{1'b0}};
            conv_run <= 8'h00;
            conv_val <= {(RES_W*8){1'b0}};
            started <= 1'b0;
            drive_line_out <= 8'h00;
            charge_capture_out <= 8'h00;
            ramp_enable_out <= 8'h00;
            discharge_out <= 8'h00;
            drive_index_out <= 3'h0;
            result_valid_out <= 1'b0;
            result_key_out <= 6'h00;
            result_value_out <= {RES_W{1'b0}};
            scan_done_out <= 1'b0;
        end
        else
        begin
            result_valid_out <= 1'b0;
            scan_done_out <= 1'b0;
            case (state)
                S_IDLE:
                begin
                    discharge_out <= 8'hff;
                    if (scan_enable_in)
                    begin
                        xi <= 3'h0; // see RQ2
                        started <= 1'b0;
                        state <= S_SEEK;
                    end
                end
                S_SEEK:
                begin
                    // skip drive lines without enabled keys, no timeslot
                    if (!line_en[xi] || burst_max == {BL_W{1'b0}})
                    begin
                        if (xi == 3'h7)
                        begin
                            // wrap to first enabled line next pass
                            xi <= 3'h0; // see RQ17 RQ9
                            scan_done_out <= started;
                            started <= 1'b0;
                            if (!scan_enable_in)
                                state <= S_IDLE;
                        end
                        else
                            // one cycle per dropped line, burst timing unchanged
                            xi <= xi + 3'h1; // see RQ3 RQ9 RQ12
                    end
                    else
                    begin
                        started <= 1'b1;
                        drive_index_out <= xi;
                        discharge_out <= 8'h00;
                        pulse <= {BL_W{1'b0}};
                        tmr <= {CNT_W{1'b0}};
                        state <= S_HIGH;
                    end
                end
                S_HIGH:
                begin
                    drive_line_out <= 8'h01 << xi; // see RQ4
                    for (i = 0; i < 8; i = i + 1)
                        charge_capture_out[i] <= (tmr < dwell) &&
                            (pulse < line_bl[i*BL_W +: BL_W]); // see RQ7 RQ8
                    if (tmr >= dwell && tmr >= HALF)
                    begin
                        tmr <= {CNT_W{1'b0}};
                        charge_capture_out <= 8'h00;
                        state <= S_LOW;
                    end
                    else
                        tmr <= tmr + {{(CNT_W-1){1'b0}}, 1'b1};
                end
                S_LOW:
                begin
                    drive_line_out <= 8'h00;
                    if (tmr >= HALF)
                    begin
                        tmr <= {CNT_W{1'b0}};
                        if (pulse + {{(BL_W-1){1'b0}}, 1'b1} >= burst_max)
                        begin
                            // burst complete before any other line moves
                            conv_cnt <= {RES_W{1'b0}}; // see RQ5
                            for (i = 0; i < 8; i = i + 1)
                                conv_run[i] <= key_en[i*8 + xi]; // see RQ8
                            ramp_enable_out <= 8'hff;
                            state <= S_CONV;
                        end
                        else
                        begin
                            pulse <= pulse + {{(BL_W-1){1'b0}}, 1'b1};
                            state <= S_HIGH;
                        end
                    end
                    else
                        tmr <= tmr + {{(CNT_W-1){1'b0}}, 1'b1};
                end
                S_CONV:
                begin
                    // single-slope: count until each comparator trips
                    conv_cnt <= conv_cnt + {{(RES_W-1){1'b0}}, 1'b1};
                    for (i = 0; i < 8; i = i + 1)
                        if (conv_run[i] && !slope_compare_in[i])
                        begin
                            conv_run[i] <= 1'b0;
                            conv_val[i*RES_W +: RES_W] <= conv_cnt; // see RQ13
                        end
                    if (conv_run == 8'h00 || conv_cnt == CONV_MAX)
                    begin
                        for (i = 0; i < 8; i = i + 1)
                            if (conv_run[i])
                                conv_val[i*RES_W +: RES_W] <= CONV_MAX;
                        ramp_enable_out <= 8'h00;
                        discharge_out <= 8'hff;
                        yi <= 3'h0;
                        state <= S_EMIT;
                    end
                end
                S_EMIT:
                begin
                    // one result per enabled receive line, in line order
                    if (key_en[{yi, xi}])
                    begin
                        result_valid_out <= 1'b1; // see RQ6 RQ8
                        result_key_out <= {yi, xi}; // see RQ1 RQ14
                        result_value_out <= conv_val[yi*RES_W +: RES_W];
                    end
                    if (yi == 3'h7)
                    begin
                        state <= S_SEEK;
                        if (xi == 3'h7)
                        begin
                            xi <= 3'h0; // see RQ17
                            scan_done_out <= 1'b1;
                            started <= 1'b0;
                            if (!scan_enable_in)
                                state <= S_IDLE;
                        end
                        else
                            xi <= xi + 3'h1; // see RQ3 RQ5
                    end
                    else
                        yi <= yi + 3'h1; // see RQ3
                end
                default:
                    state <= S_IDLE;
            endcase
        end
    end
endmodule // tmss_scan

// ---- tmss_scan_assertions.sv ----
// port checker for the touch matrix scan sequencer
`timescale 1ns/10ps
module tmss_scan_checker #(
    parameter DI_W = 8
) (
    input wire core_clk_in,
    input wire rst_in,
    input wire [64*DI_W-1:0] key_detect_integrator_in,
    input wire [7:0] drive_line_out,
    input wire [7:0] ramp_enable_out,
    input wire [2:0] drive_index_out,
    input wire result_valid_out,
    input wire [5:0] result_key_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_two; result_valid_out ##1 result_valid_out; endsequence
    sequence s_high; (|drive_line_out) [*8]; endsequence
    sequence s_low; (drive_line_out == 8'h00) [*8]; endsequence
    property p_one; $onehot0(drive_line_out); endproperty
    property p_idx;
        |drive_line_out |-> drive_line_out == (8'h01 << drive_index_out);
    endproperty
    property p_x; result_valid_out |-> result_key_out[2:0] == drive_index_out;
    endproperty
    property p_en;
        result_valid_out |-> |key_detect_integrator_in[result_key_out*DI_W +: DI_W];
    endproperty
    property p_ord; s_two |-> result_key_out[5:3] > $past(result_key_out[5:3]);
    endproperty
    property p_ramp; |ramp_enable_out |-> drive_line_out == 8'h00; endproperty
    property p_high; $rose(|drive_line_out) |-> s_high; endproperty
    property p_low; $fell(|drive_line_out) |-> s_low; endproperty
    a_one: assert property (p_one)
        else $error("two drive lines up");
    a_idx: assert property (p_idx)
        else $error("drive line and index differ");
    a_x: assert property (p_x)
        else $error("result key not on current line");
    a_en: assert property (p_en)
        else $error("result for disabled key");
    a_ord: assert property (p_ord)
        else $error("receive order broken");
    a_ramp: assert property (p_ramp)
        else $error("ramp during burst");
    a_high: assert property (p_high)
        else $error("drive pulse too short");
    a_low: assert property (p_low)
        else $error("drive gap too short");
endmodule // tmss_scan_checker
bind tmss_scan tmss_scan_checker #(.DI_W(DI_W)) u_chk (
    .core_clk_in(core_clk_in), .rst_in(rst_in),
    .key_detect_integrator_in(key_detect_integrator_in),
    .drive_line_out(drive_line_out), .ramp_enable_out(ramp_enable_out),
    .drive_index_out(drive_index_out), .result_valid_out(result_valid_out),
    .result_key_out(result_key_out));

// ---- tmss_matrix_model.sv ----
// electrode matrix model: charge per receive line, ramp comparator
`timescale 1ns/10ps
module tmss_matrix_model (
    input wire core_clk_in,
    input wire [7:0] drive_line_in,
    input wire [7:0] charge_capture_in,
    input wire [7:0] ramp_enable_in,
    input wire [7:0] discharge_in,
    output reg [7:0] slope_compare_out = 8'hff
);
    integer q [0:7];
    integer r [0:7];
    integer y;
    always @(posedge core_clk_in)
        for (y = 0; y < 8; y = y + 1)
        begin
            if (discharge_in[y])
            begin
                q[y] = 0;
                r[y] = 0;
            end
            // charge only while gated and a drive pulse is up
            q[y] = q[y] + (charge_capture_in[y] & |drive_line_in);
            r[y] = r[y] + ramp_enable_in[y];
            // crossing time grows with collected charge
            slope_compare_out[y] <= !(ramp_enable_in[y] && r[y] > q[y]);
        end
endmodule // tmss_matrix_model

// ---- testbench.sv ----
// self-checking bench for the touch matrix scan sequencer
`timescale 1ns/10ps
module testbench;
    reg core_clk_in = 1'b0;
    reg rst_in = 1'b1;
    reg scan_enable_in = 1'b0;
    reg [511:0] bl = 512'h0;
    reg [511:0] di = 512'h0;
    reg [11:0] dwell = 12'h000;
    reg [7:0] pdrv = 8'h00;
    reg [7:0] hit = 8'h00;
    wire [7:0] cmp, drv, cap, ramp, dis;
    wire [2:0] idx;
    wire rv, done;
    wire [5:0] rkey;
    wire [11:0] rval;
    integer error_cnt = 0, n_tests = 0, cyc = 0, nres = 0, nd = 0, i, j;
    integer cw = 0, wl = 0;
    integer ps [0:7];
    integer cn [0:63];
    reg [5:0] keys [0:63];
    reg [11:0] vals [0:63];
    always #5 core_clk_in = ~core_clk_in;
    tmss_scan u_tmss_scan (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .scan_enable_in(scan_enable_in), .burst_pulse_count_in(bl),
        .key_detect_integrator_in(di), .dwell_cycles_in(dwell),
        .slope_compare_in(cmp), .drive_line_out(drv), .charge_capture_out(cap),
        .ramp_enable_out(ramp), .discharge_out(dis), .drive_index_out(idx),
        .result_valid_out(rv), .result_key_out(rkey),
        .result_value_out(rval), .scan_done_out(done));
    tmss_matrix_model u_tmss_matrix_model (.core_clk_in(core_clk_in),
        .drive_line_in(drv), .charge_capture_in(cap), .ramp_enable_in(ramp),
        .discharge_in(dis), .slope_compare_out(cmp));
    task check(input string what, input [31:0] got, input [31:0] exp);
    begin
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    end
    endtask
    task finish_test;
    begin
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask
    // timeout: both scenarios together need well under two thousand cycles
    always @(posedge core_clk_in)
    begin
        cyc = cyc + 1;
        if (cyc == 60000)
        begin
            error_cnt = error_cnt + 1;
            finish_test;
        end
    end
    // monitor: results, pulses per drive line, captured pulses per key
    always @(posedge core_clk_in)
    begin
        if (rv)
        begin
            keys[nres % 64] = rkey;
            vals[rkey] = rval;
            nres = nres + 1;
        end
        nd = nd + done;
        for (i = 0; i < 8; i = i + 1)
        begin
            ps[i] = ps[i] + (drv[i] & ~pdrv[i]);
            if (pdrv != 8'h00 && drv == 8'h00)
                cn[i*8+idx] = cn[i*8+idx] + hit[i];
        end
        hit = (drv == 8'h00) ? 8'h00 : hit | cap;
        // length of the last capture window, in cycles
        if (|cap)
            cw = cw + 1;
        else if (cw != 0)
        begin
            wl = cw;
            cw = 0;
        end
        pdrv = drv;
    end
    // enable is dropped inside the last pass so exactly n passes run
    task run(input integer n);
    begin
        for (j = 0; j < 64; j = j + 1)
            cn[j] = 0;
        for (j = 0; j < 8; j = j + 1)
            ps[j] = 0;
        nres = 0;
        nd = 0;
        scan_enable_in = 1'b1;
        while (nd < n - 1 || drv == 8'h00)
            @(posedge core_clk_in) #1;
        scan_enable_in = 1'b0;
        while (nd < n)
            @(posedge core_clk_in) #1;
        repeat (40) @(posedge core_clk_in);
        #1;
        check("passes", nd, n);
        check("discharge", dis, 8'hff);
        check("ramp", ramp, 8'h00);
    end
    endtask
    task test_sparse;
        int k[5] = '{0, 8, 5, 63, 9};
        int b[5] = '{3, 5, 2, 4, 7};
        int d[5] = '{16, 16, 1, 255, 0};
        int eps[8] = '{10, 0, 0, 0, 0, 4, 0, 8};
    begin
        // unused positions stay disabled
        for (j = 0; j < 5; j = j + 1)
        begin
            bl[k[j]*8 +: 8] = b[j];
            di[k[j]*8 +: 8] = d[j];
        end
        run(2);
        check("results", nres, 8);
        for (j = 0; j < 8; j = j + 1)
            check("key", keys[j], k[j % 4]);
        for (j = 0; j < 8; j = j + 1)
            check("pulses", ps[j], eps[j]);
        for (j = 0; j < 4; j = j + 1)
        begin
            check("captures", cn[k[j]], 2 * b[j]);
            check("valid", vals[k[j]] < 12'hfff, 1);
        end
        check("gain", vals[8] > vals[0], 1);
        // zero dwell is clamped to the 125 ns floor at 10 ns
        check("dwell", wl, 13);
    end
    endtask
    task test_full;
    begin
        bl = {64{8'h01}};
        di = {64{8'h02}};
        dwell = 12'h014;
        run(1);
        check("results", nres, 64);
        for (j = 0; j < 64; j = j + 1)
            check("key", keys[j], (j % 8) * 8 + j / 8);
        for (j = 0; j < 8; j = j + 1)
            check("pulses", ps[j], 1);
        check("dwell", wl, 20);
    end
    endtask
    initial
    begin
        repeat (3) @(posedge core_clk_in);
        #1 rst_in = 1'b0;
        test_sparse;
        test_full;
        finish_test;
    end
endmodule // testbench
